// ===== verilog/asalu_pkg.sv
// Package with opcodes, field positions and widths of the AND and subtract ALU slice.
`default_nettype none
package asalu_pkg;
    localparam int ASALU_IW = 14;
    localparam int ASALU_DW = 8;
    localparam int ASALU_FW = 7;
    localparam int ASALU_D_BIT = 7;
    localparam int ASALU_NIB = 4;
    localparam logic [5:0] ASALU_OP_AND_FILE = 6'h05;
    localparam logic [5:0] ASALU_OP_FILE_SUB = 6'h02;
    localparam logic [4:0] ASALU_OP_LIT_SUB = 5'h1E;
    localparam logic [7:0] ASALU_ACC_RST = 8'h00;
    typedef enum logic [1:0] {ASALU_NONE, ASALU_AND, ASALU_FSUB, ASALU_LSUB} asalu_op_t;
endpackage : asalu_pkg
`default_nettype wire

// ===== verilog/asalu_core.sv
// AND and subtract ALU slice: decode, execute, destination routing and status flags.
// Notes on behaviour
// - AND accumulator with file; only zero flag
// - Destination bit zero to accumulator, one file
// - Literal minus accumulator into accumulator, flags updated
// - File minus accumulator to destination, flags updated
// - Subtract carry one unless borrow occurred
`timescale 1ns/1ps
`default_nettype none
module asalu_core
    import asalu_pkg::*;
#(
    parameter int DW = ASALU_DW
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Instruction from decode, with the addressed file value read beside it.
    input wire logic instr_valid,
    input wire logic [ASALU_IW-1:0] instr,
    input wire logic [DW-1:0] file_rdata,
    // File register read address and write-back.
    output logic [ASALU_FW-1:0] file_addr,
    output logic file_we,
    output logic [DW-1:0] file_wdata,
    // Accumulator and status flags.
    output logic [DW-1:0] accum_q,
    output logic zero_flag_q,
    output logic carry_flag_q,
    output logic digit_carry_flag_q
);
    // Opcode fields sit at the top of the word, their widths taken from the opcode constants.
    localparam int OP_HI = ASALU_IW - 1;
    localparam int OP6_LO = ASALU_IW - $bits(ASALU_OP_AND_FILE);
    localparam int OP5_LO = ASALU_IW - $bits(ASALU_OP_LIT_SUB);
    localparam int NIB_HI = ASALU_NIB - 1;

    // The flag and literal paths assume an eight-bit word, so any other width is refused.
    if (DW != ASALU_DW) begin : g_dw_check
        $error("asalu_core supports only an 8-bit datapath");
    end

    function automatic asalu_op_t decode(input logic [ASALU_IW-1:0] w);
        if (w[OP_HI:OP6_LO] == ASALU_OP_AND_FILE) return ASALU_AND;
        if (w[OP_HI:OP6_LO] == ASALU_OP_FILE_SUB) return ASALU_FSUB;
        if (w[OP_HI:OP5_LO] == ASALU_OP_LIT_SUB) return ASALU_LSUB;
        return ASALU_NONE;
    endfunction : decode

    // Only the two file operations carry a destination bit.
    function automatic logic is_file_op(input asalu_op_t o);
        return (o == ASALU_AND) || (o == ASALU_FSUB);
    endfunction : is_file_op

    asalu_op_t op;
    logic [DW-1:0] res;
    logic [DW:0] diff;
    logic [ASALU_NIB:0] ndiff;
    logic [DW-1:0] minuend;
    logic to_file;

    assign op = instr_valid ? decode(instr) : ASALU_NONE;
    // The address comes straight from the word so that the partner's read lands in this cycle.
    assign file_addr = instr[ASALU_FW-1:0];
    // Minuend is the literal or the file value; subtracting as a+~w+1 keeps carry = no borrow.
    assign minuend = (op == ASALU_LSUB) ? instr[DW-1:0] : file_rdata;
    assign diff = {1'b0, minuend} + {1'b0, ~accum_q} + 9'h001;
    assign ndiff = {1'b0, minuend[NIB_HI:0]} + {1'b0, ~accum_q[NIB_HI:0]} + 5'h01;
    assign res = (op == ASALU_AND) ? (accum_q & file_rdata) : diff[DW-1:0];
    // Literal subtract has no destination bit and always lands in the accumulator.
    assign to_file = instr[ASALU_D_BIT] && is_file_op(op);

    always_ff @(posedge mclk) begin
        if (rst) begin
            file_we <= 1'b0;
            file_wdata <= ASALU_ACC_RST;
        end else begin
            file_we <= (op != ASALU_NONE) && to_file;
            file_wdata <= res;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            accum_q <= ASALU_ACC_RST;
        end else if (op != ASALU_NONE && !to_file) begin
            accum_q <= res;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            zero_flag_q <= 1'b0;
            carry_flag_q <= 1'b0;
            digit_carry_flag_q <= 1'b0;
        end else if (op != ASALU_NONE) begin
            zero_flag_q <= (res == '0);
            if (op != ASALU_AND) begin
                carry_flag_q <= diff[DW];
                digit_carry_flag_q <= ndiff[ASALU_NIB];
            end
        end
    end

    // Reset clears the accumulator, the flags and the write strobe by the next edge.
    property p_reset;
        @(posedge mclk)
            rst
            |=> accum_q == ASALU_ACC_RST && !file_we && !zero_flag_q && !carry_flag_q
                && !digit_carry_flag_q;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");

    // Zero is checked against whichever destination took the result, not the internal sum.
    property p_zero;
        @(posedge mclk) disable iff (rst)
            op != ASALU_NONE
            |=> zero_flag_q == (file_we ? (file_wdata == '0) : (accum_q == '0));
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

    property p_and_keeps_carry;
        @(posedge mclk) disable iff (rst)
            op == ASALU_AND
            |=> $stable(carry_flag_q) && $stable(digit_carry_flag_q);
    endproperty
    a_and_keeps_carry: assert property (p_and_keeps_carry)
        else $error("and touched carry");

    property p_and_val;
        @(posedge mclk) disable iff (rst)
            op == ASALU_AND && !instr[ASALU_D_BIT]
            |=> accum_q == ($past(accum_q) & $past(file_rdata));
    endproperty
    a_and_val: assert property (p_and_val)
        else $error("and result wrong");

    property p_and_file;
        @(posedge mclk) disable iff (rst)
            op == ASALU_AND && instr[ASALU_D_BIT]
            |=> file_we && file_wdata == ($past(accum_q) & $past(file_rdata));
    endproperty
    a_and_file: assert property (p_and_file)
        else $error("and write-back wrong");

    property p_to_file;
        @(posedge mclk) disable iff (rst)
            is_file_op(op) && instr[ASALU_D_BIT]
            |=> file_we && $stable(accum_q);
    endproperty
    a_to_file: assert property (p_to_file)
        else $error("file write missing");

    // A write pulse may only follow an operation whose destination bit chose the file.
    property p_no_stray_write;
        @(posedge mclk) disable iff (rst)
            !(is_file_op(op) && instr[ASALU_D_BIT])
            |=> !file_we;
    endproperty
    a_no_stray_write: assert property (p_no_stray_write)
        else $error("stray file write");

    property p_lsub;
        @(posedge mclk) disable iff (rst)
            op == ASALU_LSUB
            |=> !file_we && accum_q == DW'($past(instr[DW-1:0]) - $past(accum_q));
    endproperty
    a_lsub: assert property (p_lsub)
        else $error("literal subtract wrong");

    property p_fsub;
        @(posedge mclk) disable iff (rst)
            op == ASALU_FSUB && instr[ASALU_D_BIT]
            |=> file_wdata == DW'($past(file_rdata) - $past(accum_q));
    endproperty
    a_fsub: assert property (p_fsub)
        else $error("file subtract wrong");

    property p_fsub_acc;
        @(posedge mclk) disable iff (rst)
            op == ASALU_FSUB && !instr[ASALU_D_BIT]
            |=> !file_we && accum_q == DW'($past(file_rdata) - $past(accum_q));
    endproperty
    a_fsub_acc: assert property (p_fsub_acc)
        else $error("file subtract to accumulator wrong");

    property p_carry;
        @(posedge mclk) disable iff (rst)
            op == ASALU_FSUB
            |=> carry_flag_q == ($past(file_rdata) >= $past(accum_q));
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry wrong");

    property p_lsub_carry;
        @(posedge mclk) disable iff (rst)
            op == ASALU_LSUB
            |=> carry_flag_q == ($past(instr[DW-1:0]) >= $past(accum_q));
    endproperty
    a_lsub_carry: assert property (p_lsub_carry)
        else $error("literal subtract carry wrong");

    property p_digit;
        @(posedge mclk) disable iff (rst)
            op == ASALU_LSUB
            |=> digit_carry_flag_q == ($past(instr[NIB_HI:0]) >= $past(accum_q[NIB_HI:0]));
    endproperty
    a_digit: assert property (p_digit)
        else $error("digit carry wrong");

    property p_fsub_digit;
        @(posedge mclk) disable iff (rst)
            op == ASALU_FSUB
            |=> digit_carry_flag_q == ($past(file_rdata[NIB_HI:0]) >= $past(accum_q[NIB_HI:0]));
    endproperty
    a_fsub_digit: assert property (p_fsub_digit)
        else $error("file subtract digit carry wrong");

    property p_idle;
        @(posedge mclk) disable iff (rst)
            op == ASALU_NONE
            |=> !file_we && $stable(accum_q);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle changed state");

    // Refused words must leave every flag alone, or a later AND would see stale carries.
    property p_idle_flags;
        @(posedge mclk) disable iff (rst)
            op == ASALU_NONE
            |=> $stable(zero_flag_q) && $stable(carry_flag_q) && $stable(digit_carry_flag_q);
    endproperty
    a_idle_flags: assert property (p_idle_flags)
        else $error("idle changed flags");

    c_and: cover property (@(posedge mclk) disable iff (rst) op == ASALU_AND);
    c_borrow: cover property (@(posedge mclk) disable iff (rst) op == ASALU_FSUB && !diff[DW]);
    c_lsub_zero: cover property (@(posedge mclk) disable iff (rst)
        op == ASALU_LSUB && res == '0);
    c_fsub_to_file: cover property (@(posedge mclk) disable iff (rst)
        op == ASALU_FSUB && instr[ASALU_D_BIT]);
    c_nibble_borrow: cover property (@(posedge mclk) disable iff (rst)
        op == ASALU_LSUB && !ndiff[ASALU_NIB]);
endmodule : asalu_core
`default_nettype wire

// ===== dv/asalu_file_model.sv
// File register model: combinational read, address latched for the delayed write-back.
`timescale 1ns/1ps
`default_nettype none
module asalu_file_model (
    // Clock.
    input wire logic mclk,
    // Read address and write-back from the slice.
    input wire logic [6:0] file_addr,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    // Read data.
    output logic [7:0] file_rdata
);
    logic [7:0] mem_q [128];
    logic [6:0] addr_q;
    // The write lands one edge late, so a back-to-back read of that register is forwarded.
    assign file_rdata = (file_we && addr_q == file_addr) ? file_wdata : mem_q[file_addr];
    initial for (int i = 0; i < 128; i++) mem_q[i] = 8'(i * 59);
    always @(posedge mclk) begin
        addr_q <= file_addr;
        if (file_we) mem_q[addr_q] <= file_wdata;
    end
endmodule : asalu_file_model
`default_nettype wire

// ===== dv/and_subtract_alu_ops_bench.sv
// Self-checking bench: random instruction stream checked against a reference model.
`timescale 1ns/1ps
`default_nettype none
module and_subtract_alu_ops_bench;
    import asalu_pkg::*;
    logic mclk = 0, rst = 1, instr_valid = 0, z = 0, c = 0, dig = 0, d, we;
    logic [13:0] instr = '0;
    logic [7:0] file_rdata, file_wdata, accum_q, acc = 0, r, rm [128];
    logic [6:0] file_addr, a;
    logic file_we, zero_flag_q, carry_flag_q, digit_carry_flag_q;
    logic [31:0] rs = 32'hFAF0;
    int errors = 0, cmp_count = 0, cyc = 0;
    int due_q[$], due;
    logic [19:0] exp_q[$], exp_v;
    always #2 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    asalu_core dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .accum_q(accum_q), .zero_flag_q(zero_flag_q),
        .carry_flag_q(carry_flag_q), .digit_carry_flag_q(digit_carry_flag_q));
    asalu_file_model pm (.mclk(mclk), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .file_rdata(file_rdata));
    function automatic logic [9:0] sub(input logic [7:0] x);
        return {x >= acc, x[3:0] >= acc[3:0], 8'(x - acc)};
    endfunction : sub
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xorshift
    task automatic expect_eq(input string what, input logic [7:0] want, input logic [7:0] seen);
        cmp_count++;
        if (seen !== want) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask : expect_eq
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // Results of the word taken at one edge are settled by the following falling edge.
    always @(negedge mclk) begin
        if (due_q.size() > 0 && due_q[0] == cyc) begin
            due = due_q.pop_front();
            exp_v = exp_q.pop_front();
            expect_eq("accumulator", exp_v[19:12], accum_q);
            expect_eq("zero flag", {7'h00, exp_v[11]}, {7'h00, zero_flag_q});
            expect_eq("carry flag", {7'h00, exp_v[10]}, {7'h00, carry_flag_q});
            expect_eq("digit flag", {7'h00, exp_v[9]}, {7'h00, digit_carry_flag_q});
            expect_eq("file write", {7'h00, exp_v[8]}, {7'h00, file_we});
            if (exp_v[8]) expect_eq("file data", exp_v[7:0], file_wdata);
        end
    end
    initial begin
        repeat (3000) @(posedge mclk);
        errors++;
        report_and_stop();
    end
    initial begin
        for (int i = 0; i < 128; i++) rm[i] = 8'(i * 59);
        repeat (4) @(posedge mclk);
        rst <= 0;
        due_q.push_back(cyc + 2);
        exp_q.push_back(20'h00000);
        repeat (3) @(posedge mclk);
        $display("reset test done");
        for (int k = 0; k < 600; k++) begin
            rs = xorshift(rs);
            a = rs[6:0] & 7'h07;
            d = rs[16];
            case (rs[18:17])
                2'd0: begin
                    instr <= {ASALU_OP_AND_FILE, d, a};
                    r = acc & rm[a];
                    z = (r == 8'h00);
                end
                2'd1: begin
                    instr <= {ASALU_OP_FILE_SUB, d, a};
                    {c, dig, r} = sub(rm[a]);
                end
                2'd2: begin
                    instr <= {ASALU_OP_LIT_SUB, rs[19], rs[15:8]};
                    d = 0;
                    {c, dig, r} = sub(rs[15:8]);
                end
                default: instr <= {6'h07, d, a};
            endcase
            instr_valid <= (rs[18:17] != 2'd3) || rs[20];
            if (rs[18:17] == 2'd1 || rs[18:17] == 2'd2) z = (r == 8'h00);
            we = (rs[18:17] != 2'd3) && d;
            if (rs[18:17] != 2'd3 && d) rm[a] = r;
            else if (rs[18:17] != 2'd3) acc = r;
            due_q.push_back(cyc + 2);
            exp_q.push_back({acc, z, c, dig, we, r});
            @(posedge mclk);
        end
        instr_valid <= 0;
        repeat (3) @(posedge mclk);
        if (due_q.size() != 0) begin
            errors++;
            $display("unexpected pending notes: expected 0 seen %0d", due_q.size());
        end
        $display("random instruction test done");
        report_and_stop();
    end
endmodule : and_subtract_alu_ops_bench
`default_nettype wire
